// ===== wdr_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog block.
// Assumes: clk_sys at 100 MHz, one half clock period per time unit.
// Notes:   Register offsets are indices; the byte address is four times the index.
`ifndef WDR_DEFS_SVH
`define WDR_DEFS_SVH

`define WDR_IDX_CTRL        16'hffae
`define WDR_IDX_CMD         16'hffb0
`define WDR_IDX_STAT        16'hffb2

`define WDR_F_SEL           0
`define WDR_F_WATCHDOG_RESET_FLAG          1
`define WDR_F_SWR           2
`define WDR_F_SHORT_HARDWARE_RESET_FLAG          3
`define WDR_F_LONG_HARDWARE_RESET_FLAG          4
`define WDR_F_POWER_ON_RESET_FLAG          5
`define WDR_F_RELOAD_LSB    8
`define WDR_C_SERVICE       0
`define WDR_C_END_OF_INITIALIZATION_INSTRUCTION         1
`define WDR_C_SOFTWARE_RESET_INSTRUCTION          2
`define WDR_C_DISABLE       3
`define WDR_S_ENABLED       16
`define WDR_S_END_OF_INITIALIZATION_INSTRUCTION_DONE    17
`define WDR_S_IN_RESET      18

`define WDR_RST_RELOAD      8'h00
`define WDR_RST_SEL         1'b0

`define WDR_TCL_PER_CLK     2
`define WDR_DETECT_TCL      4
`define WDR_SHORT_MAX_TCL   1038
`define WDR_LONG_MIN_TCL    1040
`define WDR_SEQ_TCL         1024
`define WDR_LATCH_FAST_TCL  6
`define WDR_LATCH_SLOW_TCL  8
`define WDR_DETECT_CLK      ((`WDR_DETECT_TCL + `WDR_TCL_PER_CLK - 1) / `WDR_TCL_PER_CLK)
`define WDR_SHORT_MAX_CLK   (`WDR_SHORT_MAX_TCL / `WDR_TCL_PER_CLK)
`define WDR_LONG_MIN_CLK    ((`WDR_LONG_MIN_TCL + `WDR_TCL_PER_CLK - 1) / `WDR_TCL_PER_CLK)
`define WDR_SEQ_CLK         ((`WDR_SEQ_TCL + `WDR_TCL_PER_CLK - 1) / `WDR_TCL_PER_CLK)
`define WDR_LATCH_FAST_CLK  ((`WDR_LATCH_FAST_TCL + `WDR_TCL_PER_CLK - 1) / `WDR_TCL_PER_CLK)
`define WDR_LATCH_SLOW_CLK  ((`WDR_LATCH_SLOW_TCL + `WDR_TCL_PER_CLK - 1) / `WDR_TCL_PER_CLK)
`define WDR_DIV_FAST        2
`define WDR_DIV_SLOW        128

`endif

// ===== wdr_pkg.sv
// Purpose: Types shared by the watchdog and reset cause block.
// Assumes: Constants come from wdr_defs.svh.
// Notes:   The whole module state is one packed struct.
package wdr_pkg;

    typedef enum logic [2:0] {ST_RUN, ST_WDT_WAIT, ST_SEQ, ST_EXTEND, ST_LATCH} wdr_state_e;

    typedef struct packed {
        logic power_on_reset_flag;
        logic long_hardware_reset_flag;
        logic short_hardware_reset_flag;
        logic software_reset_flag;
        logic watchdog_reset_flag;
    } wdr_flags_s;

    typedef struct packed {
        logic active;
        logic no_ready;
        logic waits_done;
        logic ready_n;
    } wdr_ebus_s;

    typedef struct packed {
        wdr_state_e  fsm;
        logic        hw_cause;
        logic [9:0]  low_cnt;
        logic [9:0]  seq_cnt;
        logic [6:0]  presc;
        logic [15:0] wdt_cnt;
        logic [7:0]  reload;
        logic        in_sel;
        wdr_flags_s  flags;
        logic        wdt_en;
        logic        end_of_initialization_instruction_done;
        logic        mode_async;
        logic        rst_out_n;
        logic        int_rst;
        logic        cancel_hold;
        logic        abort_ext;
        logic        float_io;
        logic        cfg_pull_hi;
        logic [15:0] cfg_latched;
        logic        ack;
        logic [31:0] dat;
    } wdr_st_s;

endpackage

// ===== wdr_top.sv
// Purpose: Watchdog timer with reset sequencing and reset cause flags.
// Assumes: All pins are synchronous to clk_sys; Wishbone classic slave, 32-bit data.
// Notes:   The instruction strobes of the core arrive as writes to a command register.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "wdr_defs.svh"

module wdr_top
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [31:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Reset pins and straps
    input  wire logic              reset_input_pin_n,
    input  wire logic              reset_mode_pin,
    input  wire logic              power_on_detect,
    input  wire logic              bidir_reset_enable,
    input  wire logic              latch_fast,
    input  wire logic [15:0]       configuration_port,
    // External bus cycle status
    input  wire wdr_pkg::wdr_ebus_s ebus,
    // Reset effects
    output logic                   reset_out_pin_n,
    output logic                   internal_reset,
    output logic                   cancel_hold,
    output logic                   abort_ext_cycle,
    output logic                   float_io,
    output logic                   cfg_pull_high,
    output logic [15:0]            cfg_latched,
    output logic                   reset_is_async
);
    import wdr_pkg::*;

    // Pin and sequence timings are whole clocks, rounded up from half periods; the short maximum is rounded down.
    localparam logic [9:0] DETECT_CLK = 10'(`WDR_DETECT_CLK);
    localparam logic [9:0] SHORT_MAX  = 10'(`WDR_SHORT_MAX_CLK);
    localparam logic [9:0] LONG_MIN   = 10'(`WDR_LONG_MIN_CLK);
    localparam logic [9:0] SEQ_CLK    = 10'(`WDR_SEQ_CLK);
    localparam logic [9:0] LATCH_FAST = 10'(`WDR_LATCH_FAST_CLK);
    localparam logic [9:0] LATCH_SLOW = 10'(`WDR_LATCH_SLOW_CLK);
    localparam logic [6:0] DIV_FAST   = 7'(`WDR_DIV_FAST - 1);
    localparam logic [6:0] DIV_SLOW   = 7'(`WDR_DIV_SLOW - 1);

    wdr_st_s st;
    wdr_st_s next_st;

    logic        bus_req;
    logic        addr_ok;
    logic [15:0] reg_idx;
    logic        wr_ctrl;
    logic        wr_cmd;
    logic        cmd_service;
    logic        cmd_end_of_initialization_instruction;
    logic        cmd_software_reset_instruction;
    logic        cmd_disable;
    logic        tick;
    logic        overflow;
    logic        pin_low;
    logic        enter_hw;
    logic [15:0] ctrl_view;

    // A request is refused while ack stands, so a strobe held into the ack cycle is not taken again in that cycle.
    assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    assign reg_idx = wb_adr_i[17:2];
    assign addr_ok = (wb_adr_i[31:18] == 14'h0000);
    assign wr_ctrl = bus_req && wb_we_i && addr_ok && (reg_idx == `WDR_IDX_CTRL);
    assign wr_cmd  = bus_req && wb_we_i && addr_ok && (reg_idx == `WDR_IDX_CMD) && wb_sel_i[0];
    assign pin_low = !reset_input_pin_n;

    // Core instructions only act while the core runs, never inside a reset sequence.
    assign cmd_service = wr_cmd && wb_dat_i[`WDR_C_SERVICE] && (st.fsm == ST_RUN);
    assign cmd_end_of_initialization_instruction   = wr_cmd && wb_dat_i[`WDR_C_END_OF_INITIALIZATION_INSTRUCTION] && (st.fsm == ST_RUN);
    assign cmd_software_reset_instruction    = wr_cmd && wb_dat_i[`WDR_C_SOFTWARE_RESET_INSTRUCTION] && (st.fsm == ST_RUN);
    assign cmd_disable = wr_cmd && wb_dat_i[`WDR_C_DISABLE] && (st.fsm == ST_RUN);

    // The prescaler runs free, so the first tick after a service may come one step early.
    assign tick     = st.presc == (st.in_sel ? DIV_SLOW : DIV_FAST);
    assign overflow = (st.fsm == ST_RUN) && st.wdt_en && tick
                      && (st.wdt_cnt == 16'hffff);

    // A low mode pin skips the filter so a reset is caught even while the clock settles.
    assign enter_hw = pin_low && (!reset_mode_pin || (st.low_cnt + 10'h001 >= DETECT_CLK));

    assign ctrl_view = {st.reload, 2'b00, st.flags.power_on_reset_flag, st.flags.long_hardware_reset_flag, st.flags.short_hardware_reset_flag,
                        st.flags.software_reset_flag, st.flags.watchdog_reset_flag, st.in_sel};

    always_comb
    begin
        next_st             = st;
        next_st.cancel_hold = 1'b0;
        next_st.abort_ext   = 1'b0;
        next_st.ack         = bus_req;
        next_st.dat         = 32'h0000_0000;

        // Read data is captured with the answer and stands only while ack does.
        if (bus_req && !wb_we_i && addr_ok)
        begin
            case (reg_idx)
                `WDR_IDX_CTRL: next_st.dat = {16'h0000, ctrl_view};
                `WDR_IDX_STAT: next_st.dat = {13'h0000, st.fsm != ST_RUN, st.end_of_initialization_instruction_done,
                                              st.wdt_en, st.wdt_cnt};
                default:       next_st.dat = 32'h0000_0000;
            endcase
        end

        // Only the select bit and the reload byte are writable; flags ignore writes.
        if (wr_ctrl && wb_sel_i[0])
        begin
            next_st.in_sel = wb_dat_i[`WDR_F_SEL];
        end
        if (wr_ctrl && wb_sel_i[1])
        begin
            next_st.reload = wb_dat_i[`WDR_F_RELOAD_LSB +: 8];
        end

        // Reset pin low time, counted while it stays low, saturating.
        if (pin_low)
        begin
            if (st.low_cnt != 10'h3ff)
            begin
                next_st.low_cnt = st.low_cnt + 10'h001;
            end
            next_st.mode_async = !reset_mode_pin;
        end
        else if (st.fsm == ST_RUN || st.fsm == ST_LATCH)
        begin
            next_st.low_cnt = 10'h000;
        end

        case (st.fsm)
            ST_RUN:
            begin
                next_st.presc = tick ? 7'h00 : st.presc + 7'h01;
                if (st.wdt_en && tick)
                begin
                    next_st.wdt_cnt = st.wdt_cnt + 16'h0001;
                end
                if (!overflow)
                begin
                    if (cmd_service)
                    begin
                        next_st.wdt_cnt    = {st.reload, 8'h00};
                        next_st.flags.watchdog_reset_flag = 1'b0;
                    end
                    if (cmd_disable && !st.end_of_initialization_instruction_done)
                    begin
                        next_st.wdt_en = 1'b0;
                    end
                end
                if (cmd_end_of_initialization_instruction)
                begin
                    next_st.end_of_initialization_instruction_done = 1'b1;
                    next_st.rst_out_n  = 1'b1;
                    next_st.flags      = '0;
                end

                // Hardware reset outranks a watchdog reset, which outranks software reset.
                if (enter_hw)
                begin
                    next_st.fsm         = ST_SEQ;
                    next_st.hw_cause    = 1'b1;
                    next_st.seq_cnt     = 10'h000;
                    next_st.rst_out_n   = 1'b0;
                    next_st.int_rst     = 1'b1;
                    next_st.cancel_hold = 1'b1;
                    next_st.abort_ext   = 1'b1;
                    next_st.float_io    = 1'b1;
                    next_st.cfg_pull_hi = 1'b1;
                    next_st.flags.watchdog_reset_flag  = overflow;
                    next_st.flags.software_reset_flag   = 1'b1;
                    next_st.flags.short_hardware_reset_flag  = 1'b1;
                    if (power_on_detect)
                    begin
                        next_st.flags.power_on_reset_flag = 1'b1;
                        next_st.flags.long_hardware_reset_flag = 1'b1;
                    end
                end
                // The sequence waits in its own state until the external bus may be cut.
                else if (overflow)
                begin
                    next_st.fsm        = ST_WDT_WAIT;
                    next_st.hw_cause   = 1'b0;
                    next_st.rst_out_n  = 1'b0;
                    next_st.flags.watchdog_reset_flag = 1'b1;
                    next_st.flags.software_reset_flag  = 1'b1;
                end
                else if (cmd_software_reset_instruction)
                begin
                    next_st.fsm         = ST_SEQ;
                    next_st.hw_cause    = 1'b0;
                    next_st.seq_cnt     = 10'h000;
                    next_st.rst_out_n   = 1'b0;
                    next_st.int_rst     = 1'b1;
                    next_st.cancel_hold = 1'b1;
                    next_st.abort_ext   = 1'b1;
                    next_st.float_io    = 1'b1;
                    next_st.cfg_pull_hi = 1'b1;
                    next_st.flags.software_reset_flag   = 1'b1;
                end
            end

            ST_WDT_WAIT:
            begin
                // A cycle without ready, or one whose ready came in time, runs to its end.
                if (!ebus.active || (ebus.waits_done && ebus.ready_n && !ebus.no_ready)
                    || pin_low)
                begin
                    next_st.fsm         = ST_SEQ;
                    next_st.seq_cnt     = 10'h000;
                    next_st.int_rst     = 1'b1;
                    next_st.cancel_hold = 1'b1;
                    next_st.abort_ext   = ebus.active;
                    next_st.float_io    = 1'b1;
                    next_st.cfg_pull_hi = 1'b1;
                end
            end

            // A low pin during the sequence marks it as hardware caused.
            ST_SEQ:
            begin
                if (pin_low)
                begin
                    next_st.hw_cause = 1'b1;
                end
                if (st.seq_cnt + 10'h001 >= SEQ_CLK)
                begin
                    if (pin_low && (bidir_reset_enable || st.hw_cause))
                    begin
                        next_st.fsm = ST_EXTEND;
                    end
                    else
                    begin
                        next_st.fsm     = ST_LATCH;
                        next_st.seq_cnt = 10'h000;
                        if (st.hw_cause && st.low_cnt <= SHORT_MAX)
                        begin
                            next_st.flags.short_hardware_reset_flag = 1'b1;
                            next_st.flags.software_reset_flag  = 1'b1;
                        end
                    end
                end
                else
                begin
                    next_st.seq_cnt = st.seq_cnt + 10'h001;
                end
            end

            // The sequence is held here for as long as the pin stays low.
            ST_EXTEND:
            begin
                next_st.flags.long_hardware_reset_flag = 1'b1;
                next_st.flags.short_hardware_reset_flag = 1'b1;
                next_st.flags.software_reset_flag  = 1'b1;
                if (!pin_low)
                begin
                    next_st.fsm     = ST_LATCH;
                    next_st.seq_cnt = 10'h000;
                    if (st.low_cnt < LONG_MIN)
                    begin
                        next_st.flags.long_hardware_reset_flag = st.flags.long_hardware_reset_flag || !st.hw_cause;
                    end
                end
            end

            // A new low pulse before the latch sends the sequence back to the extension.
            ST_LATCH:
            begin
                if (pin_low)
                begin
                    next_st.fsm     = ST_EXTEND;
                    next_st.seq_cnt = 10'h000;
                end
                else if (st.seq_cnt + 10'h001 >= (latch_fast ? LATCH_FAST : LATCH_SLOW))
                begin
                    next_st.fsm         = ST_RUN;
                    next_st.cfg_latched = configuration_port;
                    next_st.cfg_pull_hi = 1'b0;
                    next_st.int_rst     = 1'b0;
                    next_st.float_io    = 1'b0;
                    next_st.hw_cause    = 1'b0;
                    next_st.low_cnt     = 10'h000;
                end
                else
                begin
                    next_st.seq_cnt = st.seq_cnt + 10'h001;
                end
            end

            default:
            begin
                next_st.fsm = ST_RUN;
            end
        endcase

        // Every reset sequence rearms the watchdog and restarts initialisation.
        if (next_st.fsm != ST_RUN)
        begin
            next_st.wdt_en     = 1'b1;
            next_st.end_of_initialization_instruction_done = 1'b0;
            next_st.rst_out_n  = 1'b0;
            next_st.wdt_cnt    = 16'h0000;
            next_st.presc      = 7'h00;
            next_st.reload     = `WDR_RST_RELOAD;
            next_st.in_sel     = `WDR_RST_SEL;
        end
    end

    // The reset values match what a finished reset sequence leaves behind, except that the flags, cfg_latched, mode_async and seq_cnt load zero.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st             <= '0;
            st.fsm         <= ST_RUN;
            st.wdt_en      <= 1'b1;
            st.reload      <= `WDR_RST_RELOAD;
            st.in_sel      <= `WDR_RST_SEL;
            st.cfg_latched <= 16'h0000;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Every output is a field of the state register, so none has a combinational path.
    assign wb_dat_o        = st.dat;
    assign wb_ack_o        = st.ack;
    assign reset_out_pin_n = st.rst_out_n;
    assign internal_reset  = st.int_rst;
    assign cancel_hold     = st.cancel_hold;
    assign abort_ext_cycle = st.abort_ext;
    assign float_io        = st.float_io;
    assign cfg_pull_high   = st.cfg_pull_hi;
    assign cfg_latched     = st.cfg_latched;
    assign reset_is_async  = st.mode_async;

endmodule

// ===== wdr_props.sv
// Purpose: Concurrent checks on the ports of the watchdog and reset cause block.
// Assumes: Bound to wdr_top; a single clock domain with synchronous active-low reset.
// Notes:   Command strobes are decoded here from the Wishbone request itself.
`timescale 1ns/1ps
`include "wdr_defs.svh"
module wdr_props
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // Reset effects
    input wire logic [15:0] configuration_port,
    input wire logic        reset_out_pin_n,
    input wire logic        internal_reset,
    input wire logic        cancel_hold,
    input wire logic        float_io,
    input wire logic        cfg_pull_high,
    input wire logic [15:0] cfg_latched
);
    import wdr_pkg::*;
    logic cmd_wr;
    logic end_of_initialization_instruction_wr;
    assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                    && (wb_adr_i == {14'h0000, `WDR_IDX_CMD, 2'h0});
    assign end_of_initialization_instruction_wr = cmd_wr && wb_dat_i[`WDR_C_END_OF_INITIALIZATION_INSTRUCTION];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // A reset request while internal_reset stands is refused, so it is left out.
    sequence s_sw;
        s_take ##0 (cmd_wr && wb_dat_i[`WDR_C_SOFTWARE_RESET_INSTRUCTION] && !internal_reset);
    endsequence
    property p_ack_resp;
        s_take |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_reset_out_pin;
        internal_reset |-> !reset_out_pin_n;
    endproperty
    a_reset_out_pin: assert property (p_reset_out_pin) else $error("reset out high in sequence");
    property p_float;
        internal_reset |-> float_io;
    endproperty
    a_float: assert property (p_float) else $error("pins not floated in sequence");
    property p_pull;
        $rose(internal_reset) |-> cfg_pull_high;
    endproperty
    a_pull: assert property (p_pull) else $error("port pull-up missing at entry");
    property p_cancel;
        cancel_hold |=> !cancel_hold;
    endproperty
    a_cancel: assert property (p_cancel) else $error("hold cancel not a pulse");
    property p_seq;
        $rose(internal_reset) |-> internal_reset [*8];
    endproperty
    a_seq: assert property (p_seq) else $error("reset sequence cut short");
    property p_sw;
        s_sw |=> internal_reset;
    endproperty
    a_sw: assert property (p_sw) else $error("software reset not started");
    property p_end_of_initialization_instruction;
        $rose(reset_out_pin_n) |-> $past(end_of_initialization_instruction_wr) || $past(end_of_initialization_instruction_wr, 2);
    endproperty
    a_end_of_initialization_instruction: assert property (p_end_of_initialization_instruction) else $error("reset out released early");
    property p_cfg;
        $fell(internal_reset) |-> cfg_latched == $past(configuration_port);
    endproperty
    a_cfg: assert property (p_cfg) else $error("port value not latched");
endmodule

// ===== wdr_ext_reset.sv
// Purpose: External reset circuit driving the reset pin, mode pin and power-on flag.
// Assumes: Pins change just after a rising clock edge.
// Notes:   The pin has no pull-down here; a long pulse stands in for a pin held low.
`timescale 1ns/1ps
module wdr_ext_reset
(
    // Clock
    input wire logic clk_sys,
    // Pins toward the block
    output logic     reset_input_pin_n,
    output logic     reset_mode_pin,
    output logic     power_on_detect
);
    initial
    begin
        reset_input_pin_n = 1'b1;
        reset_mode_pin    = 1'b1;
        power_on_detect   = 1'b0;
    end
    // Each pulse holds the mode pin at the given mode level for the whole pin low time.
    task automatic pulse(input int len, input logic mode, input logic por);
        @(posedge clk_sys);
        reset_input_pin_n <= 1'b0;
        reset_mode_pin    <= mode;
        power_on_detect   <= por;
        repeat (len) @(posedge clk_sys);
        reset_input_pin_n <= 1'b1;
        reset_mode_pin    <= 1'b1;
        power_on_detect   <= 1'b0;
    endtask
endmodule

// ===== wdr_tb.sv
// Purpose: Self-checking bench for the watchdog and reset cause block.
// Assumes: 100 MHz clk_sys; Wishbone classic master tasks; external reset model.
// Notes:   The slow prescaler timeout runs at full length and dominates run time.
`timescale 1ns/1ps
`include "wdr_defs.svh"
module tb;
    import wdr_pkg::*;
    localparam logic [31:0] A_CTRL = {14'h0000, `WDR_IDX_CTRL, 2'h0};
    localparam logic [31:0] A_CMD  = {14'h0000, `WDR_IDX_CMD, 2'h0};
    localparam logic [31:0] A_STAT = {14'h0000, `WDR_IDX_STAT, 2'h0};
    localparam logic [31:0] ROWS [4][3] = '{'{A_CTRL, 32'hff3f, 32'hff01},
        '{A_CTRL, 32'h12c0, 32'h1200}, '{A_CTRL, 32'ha5fe, 32'ha500}, '{32'h100, 32'hff, 0}};
    localparam int HW [3][5] = '{'{100, 1, 0, 0, 'h0c}, '{600, 1, 0, 1, 'h1c},
        '{600, 0, 1, 0, 'h3c}};
    logic        clk_sys, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
    logic [3:0]  wb_sel_i;
    logic        reset_input_pin_n, reset_mode_pin, power_on_detect, bidir_reset_enable;
    logic        latch_fast, reset_out_pin_n, internal_reset, cancel_hold, abort_ext_cycle;
    logic        float_io, cfg_pull_high, reset_is_async;
    logic [15:0] configuration_port, cfg_latched;
    wdr_ebus_s   ebus;
    int          errors, compares, n, nl [3];
    wdr_top DUT (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_input_pin_n, .reset_mode_pin,
        .power_on_detect, .bidir_reset_enable, .latch_fast, .configuration_port, .ebus,
        .reset_out_pin_n, .internal_reset, .cancel_hold, .abort_ext_cycle, .float_io,
        .cfg_pull_high, .cfg_latched, .reset_is_async);
    wdr_ext_reset ext (.clk_sys, .reset_input_pin_n, .reset_mode_pin, .power_on_detect);
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int k;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50)
            errors++;
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_rst(input logic lvl, output int c);
        c = 0;
        while (internal_reset !== lvl && c < 40000)
        begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= 40000)
            errors++;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // A full-length slow timeout takes about 32770 cycles; the 100000-cycle limit leaves ample margin.
    initial
    begin
        #1_000_000;
        errors++;
        give_verdict();
    end
    initial
    begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, bidir_reset_enable, latch_fast} = '0;
        {wb_adr_i, wb_dat_i, wb_sel_i, configuration_port, ebus} = '0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        wb(0, A_CTRL, 0, q);
        chk("ctrl_reset", q, 0);
        wb(0, A_STAT, 0, q);
        chk("stat_reset", q[18:16], 3'b001);
        chk("reset_out_pin_reset", reset_out_pin_n, 0);
        for (int i = 0; i < 4; i++)
        begin
            wb(1, ROWS[i][0], ROWS[i][1], q);
            wb(0, ROWS[i][0], 0, q);
            chk("ctrl_row", q, ROWS[i][2]);
        end
        wb(1, A_CMD, 32'h8, q);
        wb(0, A_STAT, 0, q);
        chk("disable_early", q[16], 0);
        wb(1, A_CMD, 32'h4, q);
        wait_rst(1, n);
        chk("sw_entry", n, 0);
        wait_rst(0, n);
        wb(0, A_CTRL, 0, q);
        chk("sw_flags", q, 32'h4);
        wb(0, A_STAT, 0, q);
        chk("enable_after_reset", q[16], 1);
        for (int s = 0; s < 2; s++)
        begin
            wb(1, A_CTRL, {16'h0000, 8'hff, 7'h00, s[0]}, q);
            wb(1, A_CMD, 32'h1, q);
            wait_rst(1, n);
            chk("wdt_timeout", n >= 508 + 32256 * s && n <= 518 + 32256 * s, 1);
            @(negedge clk_sys);
            chk("wdt_reset_out_pin", reset_out_pin_n, 0);
            wait_rst(0, n);
        end
        wb(0, A_CTRL, 0, q);
        chk("wdt_flags", q, 32'h6);
        wb(1, A_CMD, 32'h1, q);
        wb(0, A_CTRL, 0, q);
        chk("service_clear", q, 32'h4);
        ebus <= '{active: 1'b1, no_ready: 1'b1, waits_done: 1'b0, ready_n: 1'b1};
        wb(1, A_CTRL, 32'hff00, q);
        wb(1, A_CMD, 32'h1, q);
        repeat (530) @(posedge clk_sys);
        chk("wdt_hold", {internal_reset, reset_out_pin_n}, 2'b00);
        ebus.active <= 1'b0;
        wait_rst(1, n);
        chk("wdt_done_n", n, 2);
        chk("wdt_done_abort", abort_ext_cycle, 0);
        wait_rst(0, n);
        ebus <= '{active: 1'b1, no_ready: 1'b0, waits_done: 1'b1, ready_n: 1'b1};
        wb(1, A_CTRL, 32'hff00, q);
        wb(1, A_CMD, 32'h1, q);
        wait_rst(1, n);
        chk("wdt_abort", abort_ext_cycle, 1);
        ebus <= '0;
        wait_rst(0, n);
        for (int i = 0; i < 3; i++)
        begin
            latch_fast <= 1'(HW[i][3]);
            configuration_port <= 16'h1234 + 16'(i);
            ext.pulse(HW[i][0], 1'(HW[i][1]), 1'(HW[i][2]));
            wait_rst(0, nl[i]);
            wb(1, A_CTRL, 32'h3e, q);
            wb(0, A_CTRL, 0, q);
            chk("hw_flags", q, HW[i][4]);
            chk("hw_mode", reset_is_async, !HW[i][1]);
            chk("hw_cfg", cfg_latched, 16'h1234 + 16'(i));
        end
        chk("latch_delay", nl[2] - nl[1], 1);
        wb(1, A_CMD, 32'h2, q);
        @(negedge clk_sys);
        chk("end_of_initialization_instruction_reset_out_pin", reset_out_pin_n, 1);
        wb(0, A_CTRL, 0, q);
        chk("end_of_initialization_instruction_clear", q, 0);
        wb(1, A_CMD, 32'h8, q);
        wb(0, A_STAT, 0, q);
        chk("disable_late", q[17:16], 2'b11);
        bidir_reset_enable <= 1'b1;
        wb(1, A_CMD, 32'h4, q);
        ext.pulse(600, 1'b1, 1'b0);
        wait_rst(0, n);
        wb(0, A_CTRL, 0, q);
        chk("bidir_long", q, 32'h1c);
        give_verdict();
    end
endmodule
bind wdr_top wdr_props u_props
(
    .clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .configuration_port, .reset_out_pin_n, .internal_reset, .cancel_hold,
    .float_io, .cfg_pull_high, .cfg_latched
);
